// ---- include/mrib_params.svh ----
// Purpose: Shared offsets, field positions, reset values and counts for the mode register block
// Assumes: 200 MHz core_clk
// Notes: Included by both ends, the link checker and the bench; the package does not include it
`ifndef MRIB_PARAMS_SVH
`define MRIB_PARAMS_SVH
// Mode addresses
`define MRIB_INFO_ADDR 8'h00
`define MRIB_FEAT_ADDR 8'h01
// Information register fields
`define MRIB_INFO_INIT_BIT 0
`define MRIB_INFO_TYPE_BIT 1
`define MRIB_INFO_DNV_BIT 2
`define MRIB_INFO_ZQ_LSB 3
`define MRIB_INFO_ZQ_MSB 4
// Feature register fields
`define MRIB_FEAT_BL_LSB 0
`define MRIB_FEAT_BL_MSB 2
`define MRIB_FEAT_BT_BIT 3
`define MRIB_FEAT_WC_BIT 4
`define MRIB_FEAT_WR_LSB 5
`define MRIB_FEAT_WR_MSB 7
`define MRIB_FEAT_RESET 8'h22
// Burst length codes
`define MRIB_BL4 3'h2
`define MRIB_BL8 3'h3
`define MRIB_BL16 3'h4
// Write recovery code range and offset to cycles
`define MRIB_WR_MIN 3'h1
`define MRIB_WR_MAX 3'h6
`define MRIB_WR_OFFSET 4'h2
// Self test encodings
`define MRIB_ZQ_NONE 2'h0
`define MRIB_ZQ_VDD 2'h1
`define MRIB_ZQ_GND 2'h2
`define MRIB_ZQ_OK 2'h3
// Device traits
`define MRIB_NONVOLATILE 1'h0
`define MRIB_ZQ_SUPPORTED 1'h1
// Timing: auto init and impedance calibration times in ns
`define MRIB_CLK_PERIOD_NS 5
`define MRIB_INIT_TIME_NS 200
`define MRIB_ZQCAL_TIME_NS 100
`define MRIB_INIT_CYCLES (`MRIB_INIT_TIME_NS / `MRIB_CLK_PERIOD_NS)
`define MRIB_ZQCAL_CYCLES (`MRIB_ZQCAL_TIME_NS / `MRIB_CLK_PERIOD_NS)
`endif

// ---- include/mrib_pkg.sv ----
// Purpose: Types shared by both ends of the mode register link
// Assumes: Nothing
// Notes: Constants live in mrib_params.svh
package mrib_pkg;
  // Command codes on the command/address link
  typedef enum logic [2:0] {
    MRIB_OP_READ  = 3'h0,
    MRIB_OP_WRITE = 3'h1,
    MRIB_OP_RDB   = 3'h2,
    MRIB_OP_WRB   = 3'h3,
    MRIB_OP_ZQCAL = 3'h4
  } mrib_op_e;
endpackage

// ---- include/mrib_link_if.sv ----
// Purpose: Command/address and return link between controller and device
// Assumes: Single clock shared by both ends
// Notes: No clocking block
`timescale 1ns/1ps
interface mrib_link_if;
  import mrib_pkg::*;
  logic ca_valid;
  mrib_op_e ca_op;
  logic [8:0] ca_addr;
  logic [7:0] ca_data;
  logic ca_ap;
  logic rd_valid;
  logic [7:0] rd_data;
  logic dev_busy;
  logic beat_valid;
  logic [8:0] beat_col;
  modport dev (input ca_valid, ca_op, ca_addr, ca_data, ca_ap,
               output rd_valid, rd_data, dev_busy, beat_valid, beat_col);
  modport ctl (output ca_valid, ca_op, ca_addr, ca_data, ca_ap,
               input rd_valid, rd_data, dev_busy, beat_valid, beat_col);
endinterface

// ---- logic/mrib_device.sv ----
// Purpose: Device end: information and feature mode registers, burst column ordering
// Assumes: Controller issues commands only while dev_busy is low
// Notes: Column bit 0 is forced to zero on every burst
//
// Contract
// [R1] Read-only info register at address 00h
// [R2] Invalid-data capability bit reads zero
// [R3] Self-test result encoded in bits 4:3
// [R4] Self-test field updated when calibration completes
// [R5] Fault result: factory trim, ignore calibrations
// [R6] Result 11 proves attachment, not value
// [R7] Write-only feature register at address 01h
// [R8] Burst length codes 4, 8, 16 beats
// [R9] Burst type: sequential 0, interleaved 1
// [R10] Wrap control: wrap 0, non-wrap 1
// [R11] Write recovery 3..8 cycles before precharge
// [R12] BL4 wrap order follows C1 only
// [R13] BL4 non-wrap increments linearly from start
// [R14] BL8 sequential wraps modulo 8
// [R15] BL8 interleaved is start XOR beat
// [R16] Column bit 0 treated as zero
// [R17] Reserved bits read zero via mode read
// [R18] Writes to read-only register change nothing
`timescale 1ns/1ps
`include "mrib_params.svh"
module mrib_device
  import mrib_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Link to controller
  mrib_link_if.dev link,
  // Board side: impedance pin self-test sense
  input wire logic [1:0] zq_sense,
  // Device status
  output logic init_done,
  output logic zq_factory_trim,
  output logic zq_cal_busy,
  output logic precharge_start,
  output logic [4:0] burst_beats
);
  typedef enum logic [1:0] {
    MRIB_ST_IDLE  = 2'b00,
    MRIB_ST_BURST = 2'b01,
    MRIB_ST_RECOV = 2'b11
  } mrib_state_e;

  // Column of beat k for the programmed burst mode
  function automatic logic [8:0] mrib_beat_col(input logic [7:0] cfg, input logic [8:0] st, input logic [3:0] k);
    logic [8:0] col;
    col = st;
    case (cfg[`MRIB_FEAT_BL_MSB:`MRIB_FEAT_BL_LSB])
      `MRIB_BL8: begin
        if (cfg[`MRIB_FEAT_BT_BIT])
          col[2:0] = st[2:0] ^ k[2:0]; // [R15]
        else
          col[2:0] = st[2:0] + k[2:0]; // [R14]
      end
      `MRIB_BL16: col[3:0] = st[3:0] + k;
      default: begin
        if (cfg[`MRIB_FEAT_WC_BIT])
          col = st + {5'h00, k}; // [R13]
        else
          col[1:0] = st[1:0] + k[1:0]; // [R12]
      end
    endcase
    return col;
  endfunction

  // Beat count of a burst length code; reserved codes act as 4
  function automatic logic [4:0] mrib_bl_beats(input logic [2:0] code);
    case (code)
      `MRIB_BL8: return 5'h08; // [R8]
      `MRIB_BL16: return 5'h10;
      default: return 5'h04;
    endcase
  endfunction

  localparam logic [7:0] INIT_CNT = 8'(`MRIB_INIT_CYCLES);
  localparam logic [7:0] ZQ_CNT = 8'(`MRIB_ZQCAL_CYCLES);

  mrib_state_e state;
  logic [7:0] feat;
  logic [1:0] zq_field;
  logic [7:0] init_cnt;
  logic [7:0] zq_cnt;
  logic [8:0] start_col;
  logic start_ap;
  logic start_wr;
  logic [3:0] beat;
  logic [3:0] wr_cnt;
  logic [4:0] beats_now;
  logic [7:0] info_val;
  logic take;
  logic zq_fault;

  assign take = link.ca_valid && state == MRIB_ST_IDLE;
  assign beats_now = mrib_bl_beats(feat[`MRIB_FEAT_BL_MSB:`MRIB_FEAT_BL_LSB]);
  assign zq_fault = zq_field == `MRIB_ZQ_VDD || zq_field == `MRIB_ZQ_GND;

  // Info register image; bits 7:5 and the invalid-data bit stay zero
  always_comb begin
    info_val = 8'h00; // [R17]
    info_val[`MRIB_INFO_INIT_BIT] = ~init_done; // [R1]
    info_val[`MRIB_INFO_TYPE_BIT] = `MRIB_NONVOLATILE;
    info_val[`MRIB_INFO_DNV_BIT] = 1'b0; // [R2]
    info_val[`MRIB_INFO_ZQ_MSB:`MRIB_INFO_ZQ_LSB] = zq_field; // [R3]
  end

  // Auto-initialization runs for a fixed time after reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      init_cnt <= 8'h00;
      init_done <= 1'b0;
    end else if (!init_done) begin
      init_cnt <= init_cnt + 8'h01;
      if (init_cnt == INIT_CNT - 8'h01)
        init_done <= 1'b1; // [R1]
    end
  end

  // Feature register; writes to the info address are dropped
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      feat <= `MRIB_FEAT_RESET;
    end else if (take && link.ca_op == MRIB_OP_WRITE && link.ca_addr[7:0] == `MRIB_FEAT_ADDR) begin
      feat <= link.ca_data; // [R7] [R18]
    end
  end

  // Mode register read answer one cycle after the command
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      link.rd_valid <= 1'b0;
      link.rd_data <= 8'h00;
    end else begin
      link.rd_valid <= take && link.ca_op == MRIB_OP_READ;
      if (take && link.ca_op == MRIB_OP_READ)
        link.rd_data <= (link.ca_addr[7:0] == `MRIB_INFO_ADDR) ? info_val : 8'h00; // [R17]
    end
  end

  // Impedance calibration; a fault result locks out later calibrations
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      zq_cnt <= 8'h00;
      zq_cal_busy <= 1'b0;
      zq_field <= `MRIB_ZQ_NONE;
      zq_factory_trim <= 1'b0;
    end else if (zq_cal_busy) begin
      zq_cnt <= zq_cnt - 8'h01;
      if (zq_cnt == 8'h01) begin
        zq_cal_busy <= 1'b0;
        if (`MRIB_ZQ_SUPPORTED) begin
          zq_field <= zq_sense; // [R4]
          zq_factory_trim <= zq_sense == `MRIB_ZQ_VDD || zq_sense == `MRIB_ZQ_GND; // [R5]
        end
      end
    end else if (take && link.ca_op == MRIB_OP_ZQCAL && !zq_fault) begin // [R5]
      zq_cnt <= ZQ_CNT;
      zq_cal_busy <= 1'b1;
    end
  end

  // Burst sequencer and write recovery
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= MRIB_ST_IDLE;
      start_col <= 9'h000;
      start_ap <= 1'b0;
      start_wr <= 1'b0;
      beat <= 4'h0;
      wr_cnt <= 4'h0;
      link.beat_valid <= 1'b0;
      link.beat_col <= 9'h000;
      precharge_start <= 1'b0;
    end else begin
      precharge_start <= 1'b0;
      link.beat_valid <= 1'b0;
      case (state)
        MRIB_ST_IDLE: begin
          if (take && (link.ca_op == MRIB_OP_RDB || link.ca_op == MRIB_OP_WRB)) begin
            start_col <= {link.ca_addr[8:1], 1'b0}; // [R16]
            start_ap <= link.ca_ap;
            start_wr <= link.ca_op == MRIB_OP_WRB;
            beat <= 4'h0;
            state <= MRIB_ST_BURST;
          end
        end
        MRIB_ST_BURST: begin
          link.beat_valid <= 1'b1;
          link.beat_col <= mrib_beat_col(feat, start_col, beat); // [R9] [R10]
          beat <= beat + 4'h1;
          if ({1'b0, beat} == beats_now - 5'h01) begin
            if (start_wr && start_ap) begin
              wr_cnt <= feat[`MRIB_FEAT_WR_MSB:`MRIB_FEAT_WR_LSB] + `MRIB_WR_OFFSET; // [R11]
              state <= MRIB_ST_RECOV;
            end else begin
              state <= MRIB_ST_IDLE;
            end
          end
        end
        MRIB_ST_RECOV: begin
          wr_cnt <= wr_cnt - 4'h1;
          if (wr_cnt == 4'h1) begin
            precharge_start <= 1'b1; // [R11]
            state <= MRIB_ST_IDLE;
          end
        end
        default: state <= MRIB_ST_IDLE;
      endcase
    end
  end

  // Busy and burst length status
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      link.dev_busy <= 1'b1;
      burst_beats <= 5'h04;
    end else begin
      link.dev_busy <= !init_done || take || state != MRIB_ST_IDLE && !(state == MRIB_ST_BURST
        && {1'b0, beat} == beats_now - 5'h01 && !(start_wr && start_ap))
        || state == MRIB_ST_RECOV && wr_cnt != 4'h1;
      burst_beats <= beats_now; // [R8]
    end
  end
endmodule

// ---- logic/mrib_controller.sv ----
// Purpose: Controller end: issues mode register and burst commands for a user
// Assumes: One request in flight at a time
// Notes: Illegal feature codes are refused and flagged, never sent
`timescale 1ns/1ps
`include "mrib_params.svh"
module mrib_controller
  import mrib_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Link to device
  mrib_link_if.ctl link,
  // User request
  input wire logic req_valid,
  input wire mrib_op_e req_op,
  input wire logic [8:0] req_addr,
  input wire logic [7:0] req_data,
  input wire logic req_ap,
  output logic req_ready,
  output logic req_error,
  // User answer
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic resistor_attached
);
  logic legal;
  logic sent;
  logic [2:0] bl;
  logic [2:0] wr;

  assign bl = req_data[`MRIB_FEAT_BL_MSB:`MRIB_FEAT_BL_LSB];
  assign wr = req_data[`MRIB_FEAT_WR_MSB:`MRIB_FEAT_WR_LSB];

  // Feature writes must carry defined length and recovery codes
  always_comb begin
    legal = 1'b1;
    if (req_op == MRIB_OP_WRITE && req_addr[7:0] == `MRIB_FEAT_ADDR) begin
      if (bl != `MRIB_BL4 && bl != `MRIB_BL8 && bl != `MRIB_BL16)
        legal = 1'b0; // [R8]
      if (wr < `MRIB_WR_MIN || wr > `MRIB_WR_MAX)
        legal = 1'b0; // [R11]
      if (req_data[`MRIB_FEAT_WC_BIT] && bl != `MRIB_BL4)
        legal = 1'b0; // [R14]
    end
  end

  // Command issue, one cycle pulse on the link
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      link.ca_valid <= 1'b0;
      link.ca_op <= MRIB_OP_READ;
      link.ca_addr <= 9'h000;
      link.ca_data <= 8'h00;
      link.ca_ap <= 1'b0;
      req_error <= 1'b0;
      sent <= 1'b0;
    end else begin
      link.ca_valid <= 1'b0;
      req_error <= 1'b0;
      sent <= 1'b0;
      if (req_valid && req_ready) begin
        if (legal) begin
          link.ca_valid <= 1'b1;
          link.ca_op <= req_op;
          link.ca_addr <= req_addr;
          link.ca_data <= req_data; // [R17]
          link.ca_ap <= req_ap;
          sent <= 1'b1;
        end else begin
          req_error <= 1'b1;
        end
      end
    end
  end

  // Ready only while the device is idle and nothing is in flight
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      req_ready <= 1'b0;
    else
      req_ready <= !link.dev_busy && !link.ca_valid && !sent && !(req_valid && req_ready);
  end

  // Read answers and the self-test view
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      resistor_attached <= 1'b0;
    end else begin
      rsp_valid <= link.rd_valid;
      if (link.rd_valid) begin
        rsp_data <= link.rd_data;
        if (link.ca_addr[7:0] == `MRIB_INFO_ADDR)
          resistor_attached <= link.rd_data[`MRIB_INFO_ZQ_MSB:`MRIB_INFO_ZQ_LSB] == `MRIB_ZQ_OK; // [R6]
      end
    end
  end
endmodule

// ---- test/mrib_link_checker.sv ----
// Purpose: Link assertions for the mode register block
// Assumes: Single core_clk domain, device takes a command only while not busy
// Notes: Keeps its own copy of the feature register from taken writes
`timescale 1ns/1ps
`include "mrib_params.svh"
module mrib_link_checker
  import mrib_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Command side
  input wire logic ca_valid,
  input wire mrib_op_e ca_op,
  input wire logic [8:0] ca_addr,
  input wire logic [7:0] ca_data,
  input wire logic ca_ap,
  // Return side
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  input wire logic dev_busy,
  input wire logic beat_valid,
  input wire logic [8:0] beat_col
);
  logic [7:0] feat;
  logic go;
  logic bst;
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (rst);
  // Command taken and burst command taken
  assign go = ca_valid && !dev_busy;
  assign bst = go && (ca_op == MRIB_OP_RDB || ca_op == MRIB_OP_WRB);
  // Copy of the feature register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      feat <= `MRIB_FEAT_RESET;
    else if (go && ca_op == MRIB_OP_WRITE && ca_addr[7:0] == `MRIB_FEAT_ADDR)
      feat <= ca_data;
  end
  read_answer_a: assert property (go && ca_op == MRIB_OP_READ |-> ##[1:2] rd_valid)
    else $error("mode read not answered");
  reserved_zero_a: assert property (rd_valid |-> rd_data[7:5] == 3'h0)
    else $error("reserved read bits not zero");
  dnv_zero_a: assert property (rd_valid |-> !rd_data[2])
    else $error("invalid data capability set");
  burst_busy_a: assert property (bst |=> dev_busy)
    else $error("burst taken without busy");
  burst_start_a: assert property (bst |-> ##[1:3] beat_valid)
    else $error("burst beats late");
  even_start_a: assert property ($rose(beat_valid) |-> !beat_col[0])
    else $error("burst starts on odd column");
  bl4_len_a: assert property ($rose(beat_valid) && feat[2:0] == `MRIB_BL4 |-> beat_valid[*4] ##1 !beat_valid)
    else $error("four beat burst length wrong");
  bl4_order_a: assert property (beat_valid && $past(beat_valid) && feat[2:0] == `MRIB_BL4 && !feat[4]
    |-> beat_col[8:2] == $past(beat_col[8:2]) && beat_col[1:0] == $past(beat_col[1:0]) + 2'h1)
    else $error("four beat wrap order wrong");
  nowrap_a: assert property (beat_valid && $past(beat_valid) && feat[4]
    |-> beat_col == $past(beat_col) + 9'h001)
    else $error("non wrap order wrong");
  bl8_seq_a: assert property (beat_valid && $past(beat_valid) && feat[2:0] == `MRIB_BL8 && !feat[3]
    |-> beat_col[8:3] == $past(beat_col[8:3]) && beat_col[2:0] == $past(beat_col[2:0]) + 3'h1)
    else $error("eight beat sequential order wrong");
endmodule

// ---- test/tb.sv ----
// Purpose: Self-checking bench for both ends of the mode register link
// Assumes: 200 MHz core_clk, inputs driven 1 ns after the rising edge
// Notes: Burst columns and reads are compared with a model written here
`timescale 1ns/1ps
`include "mrib_params.svh"
module tb
  import mrib_pkg::*;
;
  logic core_clk, rst, req_valid, req_ap, req_ready, req_error, rsp_valid, resistor_attached;
  logic init_done, zq_factory_trim, zq_cal_busy, precharge_start, err_seen, pc_seen;
  mrib_op_e req_op;
  logic [8:0] req_addr;
  logic [7:0] req_data, rsp_data, f;
  logic [1:0] zq_sense;
  logic [4:0] burst_beats;
  logic [4:0] cf [6] = '{5'h02, 5'h0A, 5'h12, 5'h03, 5'h0B, 5'h04};
  logic [8:0] got_q [$];
  logic [7:0] rsp_q [$];
  int n_errors, cmp_count, gap, pc_gap;
  mrib_link_if link();
  mrib_device u_mrib_device (.core_clk(core_clk), .rst(rst), .link(link), .zq_sense(zq_sense),
    .init_done(init_done), .zq_factory_trim(zq_factory_trim), .zq_cal_busy(zq_cal_busy),
    .precharge_start(precharge_start), .burst_beats(burst_beats));
  mrib_controller u_mrib_controller (.core_clk(core_clk), .rst(rst), .link(link), .req_valid(req_valid),
    .req_op(req_op), .req_addr(req_addr), .req_data(req_data), .req_ap(req_ap), .req_ready(req_ready),
    .req_error(req_error), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .resistor_attached(resistor_attached));
  mrib_link_checker u_chk (.core_clk(core_clk), .rst(rst), .ca_valid(link.ca_valid), .ca_op(link.ca_op),
    .ca_addr(link.ca_addr), .ca_data(link.ca_data), .ca_ap(link.ca_ap), .rd_valid(link.rd_valid),
    .rd_data(link.rd_data), .dev_busy(link.dev_busy), .beat_valid(link.beat_valid), .beat_col(link.beat_col));
  // Clock
  initial begin
    core_clk = 0;
    forever #2.5 core_clk = ~core_clk;
  end
  // Monitor: errors, answers, beats and precharge distance from last beat
  always @(posedge core_clk) begin
    if (req_error === 1'h1) err_seen = 1;
    if (rsp_valid === 1'h1) rsp_q.push_back(rsp_data);
    if (link.beat_valid === 1'h1) got_q.push_back(link.beat_col);
    gap = (link.beat_valid === 1'h1) ? 0 : gap + 1;
    if (precharge_start === 1'h1) begin
      pc_seen = 1;
      pc_gap = gap;
    end
  end
  task automatic tally_and_finish;
    $display("compares %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [8:0] g, input logic [8:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: saw %0h, expected %0h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Bounded wait until both ends are idle
  task automatic wait_idle;
    int k;
    tick(3);
    k = 0;
    while (!(req_ready === 1'h1 && link.dev_busy === 1'h0 && zq_cal_busy === 1'h0)) begin
      tick(1);
      k++;
      if (k > 300) begin
        n_errors++;
        tally_and_finish();
      end
    end
  endtask
  task automatic req(input mrib_op_e op, input logic [8:0] a, input logic [7:0] d, input logic ap);
    wait_idle();
    err_seen = 0;
    pc_seen = 0;
    got_q.delete();
    rsp_q.delete();
    req_op = op;
    req_addr = a;
    req_data = d;
    req_ap = ap;
    req_valid = 1;
    tick(1);
    req_valid = 0;
    wait_idle();
  endtask
  task automatic rd_info(input logic [7:0] e);
    req(MRIB_OP_READ, 9'h000, 8'h00, 1'h0);
    chk(rsp_q.size(), 9'h001);
    chk(rsp_q[0], e);
  endtask
  // Program the feature register, run one burst; mode 1 reads, mode 2 writes without precharge
  task automatic burst(input logic [7:0] fv, input int bl, input int mode);
    int s, c;
    s = $urandom & 32'h1FF;
    req(MRIB_OP_WRITE, 9'h001, fv, 1'h0);
    chk(err_seen, 1'h0);
    req(mode == 1 ? MRIB_OP_RDB : MRIB_OP_WRB, s[8:0], 8'h00, mode != 2);
    tick(12);
    chk(burst_beats, bl);
    chk(got_q.size(), bl);
    chk(pc_seen, mode == 0 || mode == 3);
    if (mode == 0 || mode == 3) chk(pc_gap, fv[7:5] + 2);
    s = s & 32'h1FE;
    for (int i = 0; i < bl; i++) begin
      if (bl == 4 && fv[4]) c = s + i;
      else if (bl == 8 && fv[3]) c = s ^ i;
      else c = (s & ~(bl - 1)) | ((s + i) & (bl - 1));
      chk(got_q[i], c[8:0]);
    end
  endtask
  initial begin
    void'($urandom(32'h3A92));
    {rst, req_valid, req_ap, err_seen, pc_seen} = 5'h10;
    {req_addr, req_data, zq_sense} = '0;
    req_op = MRIB_OP_READ;
    {n_errors, cmp_count, gap, pc_gap} = '0;
    tick(16);
    chk(link.dev_busy, 1'h1);
    chk(burst_beats, 9'h004);
    rst = 0;
    tick(20);
    chk(init_done, 1'h0);
    wait_idle();
    chk(init_done, 1'h1);
    rd_info(8'h00);
    $display("test 1 done");
    req(MRIB_OP_WRITE, 9'h000, 8'hFF, 1'h0);
    rd_info(8'h00);
    zq_sense = 2'h3;
    req(MRIB_OP_ZQCAL, 9'h000, 8'h00, 1'h0);
    rd_info(8'h18);
    chk(resistor_attached, 1'h1);
    req(MRIB_OP_READ, 9'h001, 8'h00, 1'h0);
    chk(rsp_q.size(), 9'h001);
    chk(rsp_q[0], 9'h000);
    chk(resistor_attached, 1'h1);
    $display("test 2 done");
    for (int k = 0; k < 12; k++) begin
      f = {3'($urandom_range(6, 1)), cf[k % 6]};
      burst(f, cf[k % 6][2:0] == 3'h2 ? 4 : cf[k % 6][2:0] == 3'h3 ? 8 : 16, k % 4);
    end
    $display("test 3 done");
    foreach (cf[k]) begin
      f = k == 0 ? 8'h25 : k == 1 ? 8'h33 : k == 2 ? 8'h02 : 8'hE2;
      req(MRIB_OP_WRITE, 9'h001, f, 1'h0);
      chk(err_seen, 1'h1);
    end
    chk(burst_beats, 9'h010);
    $display("test 4 done");
    zq_sense = 2'h1;
    req(MRIB_OP_ZQCAL, 9'h000, 8'h00, 1'h0);
    rd_info(8'h08);
    chk(zq_factory_trim, 1'h1);
    zq_sense = 2'h3;
    req(MRIB_OP_ZQCAL, 9'h000, 8'h00, 1'h0);
    rd_info(8'h08);
    $display("test 5 done");
    rst = 1;
    tick(2);
    chk(burst_beats, 9'h004);
    rst = 0;
    zq_sense = 2'h2;
    req(MRIB_OP_ZQCAL, 9'h000, 8'h00, 1'h0);
    rd_info(8'h10);
    chk(zq_factory_trim, 1'h1);
    chk(resistor_attached, 1'h0);
    $display("test 6 done");
    tally_and_finish();
  end
endmodule
